// ---- design/smim_regfile.v ----
// direct and extended register storage
`timescale 1ns/100ps
`default_nettype none
`include "smim_regs.vh"
module smim_regfile #(
	parameter EXT_AW = 8
) (
	input  wire        i_clk,
	input  wire        i_arst_n,
	input  wire        i_ce,
	input  wire        i_we,
	input  wire [15:0] i_waddr,
	input  wire [15:0] i_wdata,
	input  wire [15:0] i_raddr,
	output wire [15:0] o_rdata
);
	localparam EXT_N = 1 << EXT_AW;

	reg [15:0] std_q [0:31];
	reg [15:0] ext_q [0:EXT_N-1];
	integer    k;

	// pointer values below 32 fold onto the direct set
	function is_std;
		input [15:0] a;
		begin
			is_std = (a[15:5] == 11'h000);
		end
	endfunction

	// extended set aliases above its depth; depth is a parameter
	assign o_rdata = is_std(i_raddr) ? std_q[i_raddr[4:0]]
		: ext_q[i_raddr[EXT_AW-1:0]];

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (k = 0; k < 32; k = k + 1) begin
				std_q[k] <= `SMIM_DIRECT_RST;
			end
			for (k = 0; k < EXT_N; k = k + 1) begin
				ext_q[k] <= `SMIM_DIRECT_RST;
			end
		end else if (i_ce && i_we) begin
			if (is_std(i_waddr)) begin
				std_q[i_waddr[4:0]] <= i_wdata;
			end else begin
				ext_q[i_waddr[EXT_AW-1:0]] <= i_wdata;
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/smim_regs.vh ----
// constants for the serial management slave
`ifndef SMIM_REGS_VH
`define SMIM_REGS_VH

// ==========================================================
// register offsets and reset values
`define SMIM_REG_ACCESS_CTRL   5'h0d
`define SMIM_REG_ADDR_DATA     5'h0e
`define SMIM_ACCESS_CTRL_RST   16'h0000
`define SMIM_POINTER_RST       16'h0000
`define SMIM_DIRECT_RST        16'h0000

// ==========================================================
// access-control fields
`define SMIM_FUNC_HI           15
`define SMIM_FUNC_LO           14
`define SMIM_TGT_HI            4
`define SMIM_TGT_LO            0
`define SMIM_TGT_GENERAL       5'h1f
`define SMIM_FUNC_ADDR         2'h0
`define SMIM_FUNC_DATA         2'h1
`define SMIM_FUNC_INC_RW       2'h2
`define SMIM_FUNC_INC_WR       2'h3

// ==========================================================
// frame fields
`define SMIM_OP_READ           2'h2
`define SMIM_OP_WRITE          2'h1
`define SMIM_HDR_BITS          4'hc
`define SMIM_DATA_BITS         4'hf

// ==========================================================
// timing
`define SMIM_CLK_PERIOD_NS     4
`define SMIM_STRAP_SETTLE_NS   12
`define SMIM_STRAP_SETTLE_CYC  ((`SMIM_STRAP_SETTLE_NS + `SMIM_CLK_PERIOD_NS - 1) / `SMIM_CLK_PERIOD_NS)

`endif

// ---- design/smim_sync.v ----
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module smim_sync #(
	parameter W = 1
) (
	input  wire         i_clk,
	input  wire         i_arst_n,
	input  wire         i_ce,
	input  wire [W-1:0] i_d,
	output reg  [W-1:0] o_q
);
	reg [W-1:0] meta_q;

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_q <= {W{1'b0}};
			o_q    <= {W{1'b0}};
		end else if (i_ce) begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- design/smim_top.v ----
// serial management slave with indirect extended register access
`timescale 1ns/100ps
`default_nettype none
`include "smim_regs.vh"
module smim_top #(
	parameter EXT_AW = 8
) (
	input  wire       I_CLK,
	input  wire       I_ARST_N,
	input  wire       I_CE,
	input  wire       I_MDC,
	input  wire       I_MDIO,
	output reg        O_MDIO,
	output wire       O_MDIO_OE_N,
	input  wire [3:0] I_ADDR_STRAP,
	output reg  [3:0] O_BUS_ADDR,
	output reg        O_BUS_ADDR_VALID
);
	// ==========================================================
	// states
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_START = 3'h1;
	localparam [2:0] S_HDR   = 3'h2;
	localparam [2:0] S_TA    = 3'h3;
	localparam [2:0] S_DATA  = 3'h4;

	// ==========================================================
	// pin synchronisers
	wire       mdc_s;
	wire       mdio_s;
	wire [3:0] strap_s;

	smim_sync #(
		.W(2)
	) u_sync_bus (
		.i_clk    (I_CLK),
		.i_arst_n (I_ARST_N),
		.i_ce     (I_CE),
		.i_d      ({I_MDC, I_MDIO}),
		.o_q      ({mdc_s, mdio_s})
	);

	smim_sync #(
		.W(4)
	) u_sync_strap (
		.i_clk    (I_CLK),
		.i_arst_n (I_ARST_N),
		.i_ce     (I_CE),
		.i_d      (I_ADDR_STRAP),
		.o_q      (strap_s)
	);

	// ==========================================================
	// strap capture after reset release
	localparam integer SETTLE_CYC = `SMIM_STRAP_SETTLE_CYC;
	reg [3:0] settle_q;

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			settle_q         <= 4'h0;
			O_BUS_ADDR       <= 4'h0;
			O_BUS_ADDR_VALID <= 1'b0;
		end else if (I_CE && !O_BUS_ADDR_VALID) begin
			if (settle_q == SETTLE_CYC[3:0]) begin
				O_BUS_ADDR       <= strap_s;
				O_BUS_ADDR_VALID <= 1'b1;
			end else begin
				settle_q <= settle_q + 4'h1;
			end
		end
	end

	// ==========================================================
	// management clock edge
	reg  mdc_d_q;
	wire mdc_rise;

	// clock may stop; only edges advance the frame
	assign mdc_rise = mdc_s & ~mdc_d_q;

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			mdc_d_q <= 1'b0;
		end else if (I_CE) begin
			mdc_d_q <= mdc_s;
		end
	end

	// ==========================================================
	// frame state
	reg  [2:0]  state_q;
	reg  [3:0]  cnt_q;
	reg  [11:0] hdr_q;
	reg  [15:0] sh_q;
	reg         match_q;
	reg         oe_q;
	reg  [15:0] ctrl_q;
	reg  [15:0] ptr_q;
	wire [11:0] hdr_nx;
	wire [15:0] wdat;
	wire [1:0]  op_nx;
	wire [4:0]  reg_q;
	wire        is_rd;
	wire        last_data;
	wire [1:0]  func;
	wire        tgt_ok;
	wire        ptr_blk;

	assign hdr_nx    = {hdr_q[10:0], mdio_s};
	assign op_nx     = hdr_nx[11:10];
	assign reg_q     = hdr_q[4:0];
	assign is_rd     = (hdr_q[11:10] == `SMIM_OP_READ);
	assign wdat      = {sh_q[14:0], mdio_s};
	assign last_data = (state_q == S_DATA) && (cnt_q == `SMIM_DATA_BITS);
	assign func      = ctrl_q[`SMIM_FUNC_HI:`SMIM_FUNC_LO];

	// only the general address is honoured
	assign tgt_ok = (ctrl_q[`SMIM_TGT_HI:`SMIM_TGT_LO]
		== `SMIM_TGT_GENERAL);

	// control and data pair are never reached indirectly
	function blocked;
		input [15:0] a;
		begin
			blocked = (a[15:5] == 11'h000)
				&& ((a[4:0] == `SMIM_REG_ACCESS_CTRL)
				|| (a[4:0] == `SMIM_REG_ADDR_DATA));
		end
	endfunction

	// indirect hits on the pair are ignored
	assign ptr_blk = blocked(ptr_q);

	// ==========================================================
	// storage access
	wire [15:0] rf_rdata;
	wire [15:0] rf_raddr;
	wire [15:0] rf_waddr;
	wire        rf_we;
	wire        commit;
	reg  [15:0] rd_val;

	assign commit = last_data && mdc_rise && match_q && !is_rd;

	// direct access uses the register field
	assign rf_raddr = (hdr_nx[4:0] == `SMIM_REG_ADDR_DATA) ? ptr_q
		: {11'h000, hdr_nx[4:0]};
	assign rf_waddr = (reg_q == `SMIM_REG_ADDR_DATA) ? ptr_q
		: {11'h000, reg_q};

	// data modes write the selected register
	assign rf_we = commit && (reg_q != `SMIM_REG_ACCESS_CTRL)
		&& !((reg_q == `SMIM_REG_ADDR_DATA)
		&& (!tgt_ok || (func == `SMIM_FUNC_ADDR) || ptr_blk));

	smim_regfile #(
		.EXT_AW(EXT_AW)
	) u_regfile (
		.i_clk    (I_CLK),
		.i_arst_n (I_ARST_N),
		.i_ce     (I_CE),
		.i_we     (rf_we),
		.i_waddr  (rf_waddr),
		.i_wdata  (wdat),
		.i_raddr  (rf_raddr),
		.o_rdata  (rf_rdata)
	);

	// read value chosen as the header completes
	always @* begin
		rd_val = rf_rdata;
		if (hdr_nx[4:0] == `SMIM_REG_ACCESS_CTRL) begin
			rd_val = ctrl_q;
		end else if (hdr_nx[4:0] == `SMIM_REG_ADDR_DATA) begin
			if (!tgt_ok || ptr_blk) begin
				rd_val = 16'h0000;
			end
			// address mode reads back the pointer
			if (tgt_ok && (func == `SMIM_FUNC_ADDR)) begin
				rd_val = ptr_q;
			end
		end
	end

	// ==========================================================
	// frame decoder and line driver
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_q <= S_IDLE;
			cnt_q   <= 4'h0;
			hdr_q   <= 12'h000;
			sh_q    <= 16'h0000;
			match_q <= 1'b0;
			oe_q    <= 1'b0;
			O_MDIO  <= 1'b1;
		end else if (I_CE && mdc_rise) begin
			// data line taken on the rising clock edge
			case (state_q)
			S_IDLE: begin
				oe_q <= 1'b0;
				if (!mdio_s) begin
					state_q <= S_START;
				end
			end
			S_START: begin
				if (mdio_s) begin
					state_q <= S_HDR;
					cnt_q   <= 4'h0;
				end else begin
					state_q <= S_IDLE;
				end
			end
			S_HDR: begin
				hdr_q <= hdr_nx;
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == `SMIM_HDR_BITS - 4'h1) begin
					state_q <= S_TA;
					cnt_q   <= 4'h0;
					sh_q    <= rd_val;
					match_q <= ((op_nx == `SMIM_OP_READ)
						|| (op_nx == `SMIM_OP_WRITE))
						&& (hdr_nx[9:5] == {1'b0, O_BUS_ADDR})
						&& O_BUS_ADDR_VALID;
				end
			end
			S_TA: begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == 4'h0) begin
					// drive zero in second turnaround bit
					if (match_q && is_rd) begin
						oe_q   <= 1'b1;
						O_MDIO <= 1'b0;
					end
				end else begin
					state_q <= S_DATA;
					cnt_q   <= 4'h0;
					if (match_q && is_rd) begin
						O_MDIO <= sh_q[15];
						sh_q   <= {sh_q[14:0], 1'b0};
					end
				end
			end
			S_DATA: begin
				cnt_q <= cnt_q + 4'h1;
				if (match_q && is_rd) begin
					O_MDIO <= sh_q[15];
					sh_q   <= {sh_q[14:0], 1'b0};
				end else begin
					// write data shifts in, line left alone
					sh_q <= wdat;
				end
				if (cnt_q == `SMIM_DATA_BITS) begin
					state_q <= S_IDLE;
					oe_q    <= 1'b0;
					O_MDIO  <= 1'b1;
				end
			end
			default: begin
				state_q <= S_IDLE;
				oe_q    <= 1'b0;
			end
			endcase
		end
	end

	assign O_MDIO_OE_N = ~oe_q;

	// ==========================================================
	// access control and pointer
	wire rd_done;

	assign rd_done = last_data && mdc_rise && match_q && is_rd;

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ctrl_q <= `SMIM_ACCESS_CTRL_RST;
			ptr_q  <= `SMIM_POINTER_RST;
		end else if (I_CE) begin
			if (commit && (reg_q == `SMIM_REG_ACCESS_CTRL)) begin
				ctrl_q <= wdat;
			end else if (commit && (reg_q == `SMIM_REG_ADDR_DATA)
				&& tgt_ok) begin
				if (func == `SMIM_FUNC_ADDR) begin
					ptr_q <= wdat;
				// both increment modes step on writes
				end else if (func[1] && !ptr_blk) begin
					ptr_q <= ptr_q + 16'h0001;
				end
				// plain data mode keeps the pointer
			end else if (rd_done && (reg_q == `SMIM_REG_ADDR_DATA)
				&& tgt_ok && !ptr_blk) begin
				// read increments only in read-write mode
				if (func == `SMIM_FUNC_INC_RW) begin
					ptr_q <= ptr_q + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/smim_checker.sv ----
// pin assertions for the management slave
`timescale 1ns/100ps
`default_nettype none
module smim_checker #(
	parameter EXT_AW = 8
) (
	input wire logic       I_CLK,
	input wire logic       I_ARST_N,
	input wire logic       I_MDC,
	input wire logic       O_MDIO,
	input wire logic       O_MDIO_OE_N,
	input wire logic [3:0] I_ADDR_STRAP,
	input wire logic [3:0] O_BUS_ADDR,
	input wire logic       O_BUS_ADDR_VALID
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	logic [9:0] low_q;
	logic       len_ok;
	// ==========
	// drive length, 17 bit times of 16 cycles
	always @(posedge I_CLK or negedge I_ARST_N)
		if (!I_ARST_N)
			low_q <= 10'h0;
		else if (O_MDIO_OE_N)
			low_q <= 10'h0;
		else
			low_q <= low_q + 10'h1;
	// margin covers pin sampling jitter
	assign len_ok = low_q >= 10'h10c && low_q <= 10'h114;
	sequence s_low;
		$fell(I_MDC);
	endsequence
	sequence s_hold;
		$stable({O_MDIO, O_MDIO_OE_N})[*8];
	endsequence
	// ==========
	// properties
	a_bit_hold:
		assert property (s_low |-> s_hold) else $error("moved in low");
	a_idle_high:
		assert property (O_MDIO_OE_N |-> O_MDIO) else $error("idle low");
	a_ta_zero:
		assert property ($fell(O_MDIO_OE_N) |-> !O_MDIO) else $error("ta");
	a_drive_len:
		assert property ($rose(O_MDIO_OE_N) |-> len_ok) else $error("len");
	a_valid_keep:
		assert property (O_BUS_ADDR_VALID |=> O_BUS_ADDR_VALID)
		else $error("valid lost");
	a_addr_hold:
		assert property (O_BUS_ADDR_VALID |=> $stable(O_BUS_ADDR))
		else $error("address moved");
	a_addr_strap:
		assert property ($rose(O_BUS_ADDR_VALID) |-> O_BUS_ADDR == I_ADDR_STRAP)
		else $error("address wrong");
	a_valid_time:
		assert property ($rose(I_ARST_N) |-> ##[2:6] O_BUS_ADDR_VALID)
		else $error("valid late");
	a_quiet_early:
		assert property (!O_BUS_ADDR_VALID |-> O_MDIO_OE_N)
		else $error("early drive");
endmodule
bind smim_top smim_checker #(.EXT_AW(EXT_AW)) u_smim_checker (
	.I_CLK(I_CLK),
	.I_ARST_N(I_ARST_N),
	.I_MDC(I_MDC),
	.O_MDIO(O_MDIO),
	.O_MDIO_OE_N(O_MDIO_OE_N),
	.I_ADDR_STRAP(I_ADDR_STRAP),
	.O_BUS_ADDR(O_BUS_ADDR),
	.O_BUS_ADDR_VALID(O_BUS_ADDR_VALID)
);
`default_nettype wire

// ---- tb/smim_station.sv ----
// station manager model on the management clock and data line
`timescale 1ns/100ps
`default_nettype none
module smim_station (
	input  wire logic i_clk,
	input  wire logic i_o,
	input  wire logic i_oe_n,
	output var  logic o_mdc,
	output wire logic o_line
);
	logic drv;
	logic d;
	assign o_line = !i_oe_n ? i_o : (drv ? d : 1'b1);
	initial begin
		o_mdc = 1'b0;
		drv = 1'b0;
		d = 1'b1;
	end
	// 64 ns clock only in frames, sample at rise
	task automatic bit_x(input logic b, input logic en, output logic s);
		drv = en;
		d = b;
		#32 s = o_line;
		o_mdc = 1'b1;
		#32 o_mdc = 1'b0;
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [14:0] h;
		logic [17:0] t;
		logic s;
		int i;
		h = {1'b1, 2'h1, op, pa, ra};
		t = {2'h2, wd};
		@(negedge i_clk);
		for (i = 14; i >= 0; i--)
			bit_x(h[i], 1'b1, s);
		// read releases turnaround, others drive one zero
		for (i = 17; i >= 0; i--) begin
			bit_x(t[i], op != 2'h2, s);
			if (i < 16)
				rd[i] = s;
		end
		drv = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the management slave
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic [4:0] pa;
	logic       ce;
	logic [3:0] strap;
	logic       I_CLK;
	logic       I_ARST_N;
	logic       mdc;
	logic       line;
	logic       o_mdio;
	logic       oe_n;
	logic       valid;
	logic [3:0] bus_addr;
	int         bad_count;
	int         n_compared;
	int         cyc;
	smim_top #(.EXT_AW(8)) u_smim_top (
		.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_CE(ce), .I_MDC(mdc),
		.I_MDIO(line), .O_MDIO(o_mdio), .O_MDIO_OE_N(oe_n),
		.I_ADDR_STRAP(strap), .O_BUS_ADDR(bus_addr), .O_BUS_ADDR_VALID(valid)
	);
	smim_station u_smim_station (
		.i_clk(I_CLK), .i_o(o_mdio), .i_oe_n(oe_n), .o_mdc(mdc), .o_line(line)
	);
	initial begin
		I_CLK = 1'b0;
		forever #2 I_CLK = ~I_CLK;
	end
	// ==========
	// helpers
	task automatic chk(input string n, input logic [15:0] e, s);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] r, input logic [15:0] d);
		logic [15:0] x;
		u_smim_station.frame(2'h1, pa, r, d, x);
	endtask
	task automatic rd(input logic [4:0] r, input logic [15:0] e);
		logic [15:0] x;
		u_smim_station.frame(2'h2, pa, r, 16'h0, x);
		chk($sformatf("reg %h", r), e, x);
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		int i;
		for (i = 0; i < 20 && valid !== 1'b1; i++)
			@(negedge I_CLK);
		chk("bus address", 16'h000a, {12'h0, bus_addr});
		chk("address valid", 16'h0001, {15'h0, valid});
		rd(5'h03, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_direct;
		wr(5'h02, 16'h1234);
		wr(5'h1f, 16'hbeef);
		rd(5'h02, 16'h1234);
		rd(5'h1f, 16'hbeef);
		$display("test direct done");
	endtask
	task automatic t_refuse;
		logic [15:0] x;
		u_smim_station.frame(2'h1, 5'h0b, 5'h02, 16'h0bad, x);
		u_smim_station.frame(2'h1, 5'h1a, 5'h02, 16'h0bad, x);
		u_smim_station.frame(2'h0, pa, 5'h02, 16'h0bad, x);
		u_smim_station.frame(2'h3, pa, 5'h02, 16'h0bad, x);
		u_smim_station.frame(2'h2, 5'h0b, 5'h02, 16'h0, x);
		chk("foreign read", 16'hffff, x);
		rd(5'h02, 16'h1234);
		$display("test refuse done");
	endtask
	task automatic t_pointer;
		wr(5'h0d, 16'h001f);
		wr(5'h0e, 16'h0170);
		rd(5'h0e, 16'h0170);
		rd(5'h0d, 16'h001f);
		$display("test pointer done");
	endtask
	task automatic t_nopost;
		wr(5'h0d, 16'h401f);
		wr(5'h0e, 16'h0c50);
		wr(5'h0e, 16'h0c51);
		rd(5'h0e, 16'h0c51);
		rd(5'h0e, 16'h0c51);
		wr(5'h0d, 16'h001f);
		rd(5'h0e, 16'h0170);
		$display("test nopost done");
	endtask
	task automatic t_inc;
		wr(5'h0d, 16'h801f);
		wr(5'h0e, 16'h1111);
		rd(5'h0e, 16'h0000);
		wr(5'h0d, 16'h001f);
		rd(5'h0e, 16'h0172);
		wr(5'h0e, 16'h0170);
		wr(5'h0d, 16'hc01f);
		rd(5'h0e, 16'h1111);
		rd(5'h0e, 16'h1111);
		wr(5'h0e, 16'h2222);
		wr(5'h0d, 16'h001f);
		rd(5'h0e, 16'h0171);
		$display("test increment done");
	endtask
	task automatic t_target;
		wr(5'h0d, 16'h001e);
		wr(5'h0e, 16'h0170);
		rd(5'h0e, 16'h0000);
		wr(5'h0d, 16'h001f);
		rd(5'h0e, 16'h0171);
		$display("test target done");
	endtask
	task automatic t_std;
		wr(5'h0e, 16'h0002);
		wr(5'h0d, 16'h401f);
		rd(5'h0e, 16'h1234);
		wr(5'h0e, 16'h5678);
		rd(5'h02, 16'h5678);
		wr(5'h0d, 16'h001f);
		wr(5'h0e, 16'h000d);
		wr(5'h0d, 16'h401f);
		wr(5'h0e, 16'h0000);
		rd(5'h0e, 16'h0000);
		rd(5'h0d, 16'h401f);
		$display("test standard done");
	endtask
	// second reset with new straps, then a frame while frozen
	task automatic t_rearm;
		logic [15:0] x;
		int i;
		@(negedge I_CLK);
		I_ARST_N = 1'b0;
		strap = 4'h5;
		repeat (5) @(negedge I_CLK);
		I_ARST_N = 1'b1;
		for (i = 0; i < 20 && valid !== 1'b1; i++)
			@(negedge I_CLK);
		chk("new bus address", 16'h0005, {12'h0, bus_addr});
		pa = 5'h05;
		rd(5'h02, 16'h0000);
		wr(5'h02, 16'h0abc);
		u_smim_station.frame(2'h1, 5'h0a, 5'h02, 16'h0bad, x);
		rd(5'h02, 16'h0abc);
		ce = 1'b0;
		wr(5'h02, 16'h0dea);
		ce = 1'b1;
		rd(5'h02, 16'h0abc);
		$display("test rearm done");
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// limit near 94 frames of 528 cycles each; the scenarios use 56
	always @(posedge I_CLK) begin
		cyc++;
		if (cyc == 50000) begin
			bad_count++;
			report_and_stop;
		end
	end
	initial begin
		bad_count = 0;
		n_compared = 0;
		cyc = 0;
		pa = 5'h0a;
		ce = 1'b1;
		strap = 4'ha;
		I_ARST_N = 1'b0;
		repeat (5) @(negedge I_CLK);
		I_ARST_N = 1'b1;
		t_reset;
		t_direct;
		t_refuse;
		t_pointer;
		t_nopost;
		t_inc;
		t_target;
		t_std;
		t_rearm;
		report_and_stop;
	end
endmodule
`default_nettype wire
